//--- core/phpd_consts.vh
// constants for the peak and hold predriver control block
// assumes inclusion by bare name from the core design files
`ifndef PHPD_CONSTS_VH
`define PHPD_CONSTS_VH
`define PHPD_FRAME_BITS 5'h10
`define PHPD_CNT_W 5
`define PHPD_WR_BIT 15
`define PHPD_ADDR_HI 14
`define PHPD_ADDR_LO 12
`define PHPD_DATA_HI 6
`define PHPD_ADDR_AUX 3'h1
`define PHPD_ADDR_PEAK 3'h2
`define PHPD_ADDR_HOLD 3'h3
`define PHPD_AUX_DWELL_HI 2
`define PHPD_AUX_SRC_BIT 3
`define PHPD_AUX_OVLO_BIT 6
`define PHPD_AUX_RST 7'h00
`define PHPD_PEAK_RST 7'h00
`define PHPD_HOLD_RST 7'h00
`define PHPD_FAULT_RST 4'h0
`define PHPD_SCLK_MAX_KHZ 4000
`define PHPD_CLK_KHZ 100000
`define PHPD_SCLK_MIN_CYC ((`PHPD_CLK_KHZ + `PHPD_SCLK_MAX_KHZ - 1) / `PHPD_SCLK_MAX_KHZ)
`endif

//--- core/phpd_sync.v
// two flip-flop synchroniser for the pin inputs of the predriver control
// assumes all seven inputs are asynchronous to core_clk
`timescale 1ns/1ps
module phpd_sync (
	input wire core_clk,
	input wire sys_rst,
	input wire [6:0] async_in,
	output reg [6:0] sync_out
);
	reg [6:0] meta_q;
	// chip select idles high so that a reset never looks like a selected frame
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= 7'h08;
			sync_out <= 7'h08;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

//--- core/phpd_ctrl.v
// Operation
// (RQ1) drive command is permit AND cycle control
// (RQ2) dwell select chooses peak or hold reference
// (RQ3) aux bit 3: 0 clock mode, 1 level
// (RQ4) serial activity only while chip select low
// (RQ5) serial output released while chip select high
// (RQ6) shift in data, shift out status together
// (RQ7) sixteen bit frames, serial clock to 4 MHz
// (RQ8) compare load current with selected 7-bit reference
// (RQ9) loop output low while current below reference
// (RQ10) fault pulls open-drain low, details readable serially
// (RQ11) aux bit 6 with overvoltage disables gate only
// (RQ12) apply word at chip select rise after sixteen clocks
//
// top of the digital control section; load current arrives as a 7-bit
// sample and fault events as one-cycle pulses from core_clk logic
`timescale 1ns/1ps
`include "phpd_consts.vh"
module phpd_ctrl (
	input wire core_clk,
	input wire sys_rst,
	input wire output_permit,
	input wire cycle_ctrl,
	input wire dwell_select,
	input wire chip_select_low,
	input wire sclk,
	input wire sdi,
	input wire ovlo_detect,
	input wire [6:0] load_current,
	input wire [3:0] fault_events,
	output reg sdo_q,
	output reg sdo_oe_q,
	output reg loop_q,
	output reg fault_out_q,
	output reg fault_oe_q,
	output reg gate_cmd_q,
	output reg clamp_cmd_q,
	output reg peak_sel_q
);
	wire [6:0] s;
	wire permit_s;
	wire cycle_s;
	wire dwell_s;
	wire csn_s;
	wire sclk_s;
	wire sdi_s;
	wire ovlo_s;
	reg csn_d1_q;
	reg sclk_d1_q;
	reg dwell_d1_q;
	reg cmd_d1_q;
	reg [15:0] shift_q;
	reg [4:0] bit_cnt_q;
	reg [6:0] aux_q;
	reg [6:0] peak_q;
	reg [6:0] hold_q;
	reg [3:0] fault_q;
	reg [2:0] dwell_cnt_q;
	reg dwell_done_q;
	wire cs_fall;
	wire cs_rise;
	wire sclk_rise;
	wire sclk_fall;
	wire dwell_rise;
	wire drive_cmd;
	wire ov_lock;
	wire use_peak;
	wire [6:0] ref_val;
	wire below;
	wire frame_ok;
	wire [2:0] wr_addr;
	wire [15:0] status_word;

	// edge finders on synchronised levels; prev_v is the level one core cycle earlier
	function rise_of;
		input now_v;
		input prev_v;
		begin
			rise_of = now_v & ~prev_v;
		end
	endfunction

	function fall_of;
		input now_v;
		input prev_v;
		begin
			fall_of = ~now_v & prev_v;
		end
	endfunction

	phpd_sync u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in({ovlo_detect, sdi, sclk, chip_select_low, dwell_select, cycle_ctrl, output_permit}),
		.sync_out(s)
	);
	assign permit_s = s[0];
	assign cycle_s = s[1];
	assign dwell_s = s[2];
	assign csn_s = s[3];
	assign sclk_s = s[4];
	assign sdi_s = s[5];
	assign ovlo_s = s[6];

	assign cs_fall = fall_of(csn_s, csn_d1_q);
	assign cs_rise = rise_of(csn_s, csn_d1_q);
	// edges only count while selected; sclk limit leaves over 12 core cycles per phase
	assign sclk_rise = ~csn_s & rise_of(sclk_s, sclk_d1_q); // RQ4
	assign sclk_fall = ~csn_s & fall_of(sclk_s, sclk_d1_q); // RQ4
	assign dwell_rise = rise_of(dwell_s, dwell_d1_q);
	assign drive_cmd = permit_s & cycle_s; // RQ1
	assign ov_lock = aux_q[`PHPD_AUX_OVLO_BIT] & ovlo_s; // RQ11
	// clock mode: peak until one more than the programmed count of dwell clocks after drive start
	assign use_peak = aux_q[`PHPD_AUX_SRC_BIT] ? dwell_s : ~dwell_done_q; // RQ2 RQ3
	assign ref_val = use_peak ? peak_q : hold_q; // RQ2
	assign below = load_current < ref_val; // RQ8
	assign frame_ok = bit_cnt_q == `PHPD_FRAME_BITS; // RQ7 RQ12
	assign wr_addr = shift_q[`PHPD_ADDR_HI:`PHPD_ADDR_LO];
	assign status_word = {fault_q, ovlo_s, ~below, use_peak, drive_cmd, 1'b0, aux_q}; // RQ10

	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			csn_d1_q <= 1'b1;
			sclk_d1_q <= 1'b0;
			dwell_d1_q <= 1'b0;
			cmd_d1_q <= 1'b0;
		end else begin
			csn_d1_q <= csn_s;
			sclk_d1_q <= sclk_s;
			dwell_d1_q <= dwell_s;
			cmd_d1_q <= drive_cmd;
		end
	end

	// serial shift register, mode 0: sample on rise, present on fall
	// sdo_oe_q trails the pin by three core cycles; the first sclk edge comes later anyway
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_q <= 16'h0000;
			bit_cnt_q <= 5'h00;
			sdo_q <= 1'b0;
			sdo_oe_q <= 1'b0;
		end else begin
			sdo_oe_q <= ~csn_s; // RQ5
			if (cs_fall) begin
				shift_q <= status_word; // RQ6
				sdo_q <= status_word[15];
				bit_cnt_q <= 5'h00;
			end else if (sclk_rise) begin
				shift_q <= {shift_q[14:0], sdi_s}; // RQ6
				if (bit_cnt_q != 5'h1f)
					bit_cnt_q <= bit_cnt_q + 5'h01;
			end else if (sclk_fall) begin
				sdo_q <= shift_q[15]; // RQ6
			end
		end
	end

	// unknown addresses write nothing, so a stray frame cannot move a reference
	// registers change only on a clean sixteen clock frame; a short or long one is dropped
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aux_q <= `PHPD_AUX_RST; // RQ3
			peak_q <= `PHPD_PEAK_RST;
			hold_q <= `PHPD_HOLD_RST;
		end else if (cs_rise && frame_ok && shift_q[`PHPD_WR_BIT]) begin // RQ12
			case (wr_addr)
				`PHPD_ADDR_AUX: aux_q <= shift_q[`PHPD_DATA_HI:0];
				`PHPD_ADDR_PEAK: peak_q <= shift_q[`PHPD_DATA_HI:0];
				`PHPD_ADDR_HOLD: hold_q <= shift_q[`PHPD_DATA_HI:0];
				default: aux_q <= aux_q;
			endcase
		end
	end

	// sticky fault details, cleared by a valid frame; a new event wins over the clear
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_q <= `PHPD_FAULT_RST;
		end else if (cs_rise && frame_ok) begin
			fault_q <= fault_events; // RQ10
		end else begin
			fault_q <= fault_q | fault_events; // RQ10
		end
	end

	// dwell counter restarts at every rising drive command
	// a stray dwell edge after reset is harmless: the next drive start clears the count
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dwell_cnt_q <= 3'h0;
			dwell_done_q <= 1'b0;
		end else if (drive_cmd && !cmd_d1_q) begin
			dwell_cnt_q <= 3'h0;
			dwell_done_q <= 1'b0;
		end else if (dwell_rise && !dwell_done_q) begin // RQ3
			dwell_cnt_q <= dwell_cnt_q + 3'h1;
			if (dwell_cnt_q == aux_q[`PHPD_AUX_DWELL_HI:0])
				dwell_done_q <= 1'b1;
		end
	end

	// fault pad is open drain: its data stays low and the enable carries the fault
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			loop_q <= 1'b0;
			fault_out_q <= 1'b0;
			fault_oe_q <= 1'b0;
			gate_cmd_q <= 1'b0;
			clamp_cmd_q <= 1'b0;
			peak_sel_q <= 1'b1;
		end else begin
			loop_q <= ~below; // RQ9
			fault_out_q <= 1'b0;
			fault_oe_q <= (|fault_q) | (|fault_events) | ov_lock; // RQ10
			gate_cmd_q <= drive_cmd & below & ~ov_lock; // RQ1 RQ8 RQ11
			// clamp keeps recirculating while drive_cmd is high and the gate is off, also under lockout
			clamp_cmd_q <= drive_cmd & ~(below & ~ov_lock); // RQ11
			peak_sel_q <= use_peak; // RQ2
		end
	end
endmodule

//--- sim/phpd_sva.sv
// port assertions for phpd_ctrl; assumes a bind from the bench top
`timescale 1ns/1ps
module phpd_sva (
	input wire core_clk,
	input wire sys_rst,
	input wire output_permit,
	input wire cycle_ctrl,
	input wire chip_select_low,
	input wire [6:0] load_current,
	input wire [3:0] fault_events,
	input wire sdo_oe_q,
	input wire loop_q,
	input wire fault_out_q,
	input wire fault_oe_q,
	input wire gate_cmd_q,
	input wire clamp_cmd_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_o0; chip_select_low [*5] |-> !sdo_oe_q; endproperty
	a_o0: assert property (p_o0) else $error("sdo kept");
	property p_o1; !chip_select_low [*5] |-> sdo_oe_q; endproperty
	a_o1: assert property (p_o1) else $error("sdo off");
	property p_en; !(output_permit && cycle_ctrl) [*5] |-> !(gate_cmd_q || clamp_cmd_q); endproperty
	a_en: assert property (p_en) else $error("drive");
	property p_gc; !(gate_cmd_q && clamp_cmd_q); endproperty
	a_gc: assert property (p_gc) else $error("both");
	property p_lp; load_current == 7'h7f |=> loop_q; endproperty
	a_lp: assert property (p_lp) else $error("loop");
	property p_ft; |fault_events |=> fault_oe_q; endproperty
	a_ft: assert property (p_ft) else $error("fault");
	property p_od; !fault_out_q; endproperty
	a_od: assert property (p_od) else $error("od");
	property p_fc; $fell(fault_oe_q) |-> chip_select_low; endproperty
	a_fc: assert property (p_fc) else $error("clear");
endmodule

//--- sim/phpd_host.sv
// host serial master model; assumes xfer is called with chip select idle
`timescale 1ns/1ps
module phpd_host (
	output reg chip_select_low = 1'b1,
	output reg sclk = 1'b0,
	output reg sdi = 1'b0,
	input wire sdo_q,
	input wire sdo_oe_q
);
	task xfer(input [15:0] w, input [4:0] n, output [15:0] r);
		chip_select_low = 1'b0;
		for (int i = 0; i < n; i = i + 1) begin
			sdi = w[15 - i];
			#80 sclk = 1'b1;
			r = {r[14:0], sdo_oe_q ? sdo_q : 1'bx};
			#80 sclk = 1'b0;
		end
		#80 chip_select_low = 1'b1;
		sdi = ~sdi;
		#200;
	endtask
endmodule

//--- sim/phpd_ctrl_tb_top.sv
// bench for phpd_ctrl with phpd_host on the serial pins; assumes core and checker compiled first
`timescale 1ns/1ps
module phpd_ctrl_tb_top;
	reg core_clk = 1'b0, sys_rst = 1'b1;
	reg output_permit = 1'b0, cycle_ctrl = 1'b0, dwell_select = 1'b1, ovlo_detect = 1'b0;
	reg [6:0] load_current = 7'h00;
	reg [3:0] fault_events = 4'h0;
	reg [15:0] rx;
	wire chip_select_low, sclk, sdi, sdo_q, sdo_oe_q, loop_q, fault_out_q, fault_oe_q, gate_cmd_q, clamp_cmd_q, peak_sel_q;
	integer error_cnt = 0, comparisons = 0;
	phpd_ctrl DUT (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.output_permit(output_permit),
		.cycle_ctrl(cycle_ctrl),
		.dwell_select(dwell_select),
		.chip_select_low(chip_select_low),
		.sclk(sclk),
		.sdi(sdi),
		.ovlo_detect(ovlo_detect),
		.load_current(load_current),
		.fault_events(fault_events),
		.sdo_q(sdo_q),
		.sdo_oe_q(sdo_oe_q),
		.loop_q(loop_q),
		.fault_out_q(fault_out_q),
		.fault_oe_q(fault_oe_q),
		.gate_cmd_q(gate_cmd_q),
		.clamp_cmd_q(clamp_cmd_q),
		.peak_sel_q(peak_sel_q)
	);
	phpd_host host (
		.chip_select_low(chip_select_low),
		.sclk(sclk),
		.sdi(sdi),
		.sdo_q(sdo_q),
		.sdo_oe_q(sdo_oe_q)
	);
	initial forever #5 core_clk = ~core_clk;
	task chk(input [15:0] e, input [15:0] g, input [39:0] nm);
		comparisons = comparisons + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("wrong value %0s exp %h got %h", nm, e, g);
		end
	endtask
	task x(input [15:0] w); host.xfer(w, 5'h10, rx); endtask
	task t_spi;
		x(16'h9008);
		x(16'h0000);
		chk(16'h0708, rx, "stat");
		host.xfer(16'h9000, 5'h0f, rx);
		x(16'h0000);
		chk(16'h0708, rx, "short");
		$display("t_spi end");
	endtask
	task t_loop;
		x(16'ha040);
		x(16'hb010);
		load_current = 7'h7f;
		#20 load_current = 7'h20;
		#60 chk(16'h5, {loop_q, gate_cmd_q, clamp_cmd_q, peak_sel_q}, "peak");
		dwell_select = 1'b0;
		#60 chk(16'ha, {loop_q, gate_cmd_q, clamp_cmd_q, peak_sel_q}, "hold");
		$display("t_loop end");
	endtask
	task t_fault;
		fault_events = 4'h2;
		#10 fault_events = 4'h0;
		#10 chk(16'h1, fault_oe_q, "fon");
		x(16'h0000);
		chk(16'h2, rx[15:12], "fbit");
		chk(16'h0, fault_oe_q, "fclr");
		dwell_select = 1'b1;
		ovlo_detect = 1'b1;
		x(16'h9048);
		chk(16'h3, {gate_cmd_q, clamp_cmd_q, fault_oe_q}, "ovlo");
		$display("t_fault end");
	endtask
	task t_reset;
		sys_rst = 1'b1;
		#20 chk(16'h01, {loop_q, gate_cmd_q, clamp_cmd_q, fault_oe_q, sdo_oe_q, peak_sel_q}, "rout");
		sys_rst = 1'b0;
		#60 x(16'h0000);
		chk(16'h100, {rx[15:11], rx[7:0]}, "rstat");
		chk(16'h0, fault_oe_q, "rfo");
		$display("t_reset end");
	endtask
	task t_dwell;
		x(16'h9002);
		dwell_select = 1'b0;
		output_permit = 1'b0;
		#60 output_permit = 1'b1;
		for (int k = 1; k <= 3; k = k + 1) begin
			#60 dwell_select = 1'b1;
			#40 dwell_select = 1'b0;
			#40 chk((k == 3) ? 16'h0 : 16'h1, peak_sel_q, "dwell");
		end
		$display("t_dwell end");
	endtask
	task report_and_stop;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		#60 {output_permit, cycle_ctrl} = 2'h3;
		#60 t_spi;
		t_loop;
		t_fault;
		t_reset;
		t_dwell;
		report_and_stop;
	end
endmodule
bind phpd_ctrl phpd_sva u_sva (
	.core_clk(core_clk),
	.sys_rst(sys_rst),
	.output_permit(output_permit),
	.cycle_ctrl(cycle_ctrl),
	.chip_select_low(chip_select_low),
	.load_current(load_current),
	.fault_events(fault_events),
	.sdo_oe_q(sdo_oe_q),
	.loop_q(loop_q),
	.fault_out_q(fault_out_q),
	.fault_oe_q(fault_oe_q),
	.gate_cmd_q(gate_cmd_q),
	.clamp_cmd_q(clamp_cmd_q)
);
